// ==== bvs_consts.svh ====
// Behaviour
// - Bit 7 clear synchronous, set sleep
// - Core-1 code: 0.30 V, 10 mV steps
// - Processor code: 0.53 V, 10 mV steps
// - Memory, I/O, peripheral: 0.80 V, 20 mV steps
// - Sleep bit counts only in mode 00 with A selected
`ifndef BVS_CONSTS_SVH
`define BVS_CONSTS_SVH

// Register indices, byte address is four times the index
`define BVS_IDX_CORE1_A 8'ha4
`define BVS_IDX_PROC_A 8'ha5
`define BVS_IDX_MEM_A 8'ha6
`define BVS_IDX_IO_A 8'ha7
`define BVS_IDX_PERI_A 8'ha8
`define BVS_IDX_MODE 8'hb0
`define BVS_IDX_STATUS 8'hb1

// Field positions
`define BVS_SLEEP_BIT 7
`define BVS_CODE_MSB 6
`define BVS_MODE_SEL_BIT 16

// Reset values
`define BVS_RST_VOLT 8'h00
`define BVS_RST_MODE 10'h000
`define BVS_RST_ASEL 1'b1

// Mode field codes
`define BVS_MODE_REG 2'h0
`define BVS_MODE_SLEEP 2'h1
`define BVS_MODE_SYNC 2'h2
`define BVS_MODE_AUTO 2'h3

// Voltage scale in millivolts
`define BVS_CORE1_BASE_MV 12'h12c
`define BVS_PROC_BASE_MV 12'h212
`define BVS_WIDE_BASE_MV 12'h320
`define BVS_FINE_STEP_MV 12'h00a
`define BVS_WIDE_STEP_MV 12'h014

// Bus responses
`define BVS_RESP_OKAY 2'h0
`define BVS_RESP_SLVERR 2'h2

`endif

// ==== bvs_pkg.sv ====
`default_nettype none
package bvs_pkg;

    typedef enum logic [1:0] {
        BVS_OP_SYNC,
        BVS_OP_SLEEP,
        BVS_OP_AUTO,
        BVS_OP_B_SET
    } bvs_op_t;

    typedef struct packed {
        bvs_op_t op;
        logic [11:0] mv;
    } bvs_rail_t;

    typedef struct packed {
        logic [4:0][7:0] volt;
        logic [9:0] mode;
        logic a_sel;
        logic aw_have;
        logic [11:0] aw_addr;
        logic w_have;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } bvs_state_t;

endpackage : bvs_pkg
`default_nettype wire

// ==== bvs_rail.sv ====
`include "bvs_consts.svh"
`default_nettype none
module bvs_rail #(
    parameter logic [11:0] BASE_MV = `BVS_CORE1_BASE_MV,
    parameter logic [11:0] STEP_MV = `BVS_FINE_STEP_MV
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] setting,
    input wire logic [1:0] mode,
    input wire logic a_sel,
    output var bvs_pkg::bvs_rail_t rail
);

    bvs_pkg::bvs_rail_t rail_r;
    bvs_pkg::bvs_rail_t rail_nxt;

    assign rail = rail_r;

    always_comb
    begin
        rail_nxt = rail_r;
        // Linear code to millivolts
        rail_nxt.mv = BASE_MV + STEP_MV * {5'h00, setting[`BVS_CODE_MSB:0]};
        unique case (mode)
            `BVS_MODE_REG:
            begin
                if (!a_sel)
                    rail_nxt.op = bvs_pkg::BVS_OP_B_SET;
                else if (setting[`BVS_SLEEP_BIT])
                    rail_nxt.op = bvs_pkg::BVS_OP_SLEEP;
                else
                    rail_nxt.op = bvs_pkg::BVS_OP_SYNC;
            end
            `BVS_MODE_SLEEP: rail_nxt.op = bvs_pkg::BVS_OP_SLEEP;
            `BVS_MODE_SYNC: rail_nxt.op = bvs_pkg::BVS_OP_SYNC;
            `BVS_MODE_AUTO: rail_nxt.op = bvs_pkg::BVS_OP_AUTO;
        endcase
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            rail_r <= '{op: bvs_pkg::BVS_OP_SYNC, mv: BASE_MV};
        else
            rail_r <= rail_nxt;
    end

    sleep_bit_a: assert property (@(posedge mclk) disable iff (rst)
        (mode == `BVS_MODE_REG && a_sel)
        |=> (rail.op == ($past(setting[`BVS_SLEEP_BIT]) ?
            bvs_pkg::BVS_OP_SLEEP : bvs_pkg::BVS_OP_SYNC)))
        else $error("A sleep bit not applied");

    forced_mode_a: assert property (@(posedge mclk) disable iff (rst)
        (mode == `BVS_MODE_AUTO) |=> (rail.op == bvs_pkg::BVS_OP_AUTO))
        else $error("Automatic mode not forced");

    forced_sleep_a: assert property (@(posedge mclk) disable iff (rst)
        (mode == `BVS_MODE_SLEEP && !setting[`BVS_SLEEP_BIT])
        |=> (rail.op == bvs_pkg::BVS_OP_SLEEP))
        else $error("Sleep mode not forced");

    b_setting_a: assert property (@(posedge mclk) disable iff (rst)
        (mode == `BVS_MODE_REG && !a_sel) |=> (rail.op == bvs_pkg::BVS_OP_B_SET))
        else $error("A bit used while B selected");

endmodule : bvs_rail
`default_nettype wire

// ==== bvs_top.sv ====
// Register access over AXI4-Lite was chosen for this implementation.
`include "bvs_consts.svh"
`default_nettype none
module bvs_top (
    input wire logic mclk,
    input wire logic rst,
    input wire logic awvalid,
    output logic awready,
    input wire logic [11:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [11:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output var bvs_pkg::bvs_rail_t [4:0] rail
);

    localparam int NRAIL = 5;

    localparam logic [4:0][7:0] VOLT_IDX = {
        `BVS_IDX_PERI_A,
        `BVS_IDX_IO_A,
        `BVS_IDX_MEM_A,
        `BVS_IDX_PROC_A,
        `BVS_IDX_CORE1_A
    };

    localparam logic [4:0][11:0] BASE_MV = {
        `BVS_WIDE_BASE_MV,
        `BVS_WIDE_BASE_MV,
        `BVS_WIDE_BASE_MV,
        `BVS_PROC_BASE_MV,
        `BVS_CORE1_BASE_MV
    };

    localparam logic [4:0][11:0] STEP_MV = {
        `BVS_WIDE_STEP_MV,
        `BVS_WIDE_STEP_MV,
        `BVS_WIDE_STEP_MV,
        `BVS_FINE_STEP_MV,
        `BVS_FINE_STEP_MV
    };

    localparam logic [11:0] ADDR_MODE = {2'h0, `BVS_IDX_MODE, 2'h0};
    localparam logic [11:0] ADDR_STATUS = {2'h0, `BVS_IDX_STATUS, 2'h0};
    localparam logic [11:0] ADDR_CORE1 = {2'h0, `BVS_IDX_CORE1_A, 2'h0};
    localparam logic [11:0] ADDR_PERI = {2'h0, `BVS_IDX_PERI_A, 2'h0};

    bvs_pkg::bvs_state_t st_r;
    bvs_pkg::bvs_state_t st_nxt;
    logic wr_hit;
    logic rd_hit;
    logic [31:0] rd_data;
    logic [31:0] status_word;

    function automatic logic [11:0] volt_addr(input logic [7:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction : volt_addr

    // Handshake outputs
    assign awready = !st_r.aw_have;
    assign wready = !st_r.w_have;
    assign arready = !st_r.rvalid;

    // Data and response outputs from flops
    assign bvalid = st_r.bvalid;
    assign bresp = st_r.bresp;
    assign rvalid = st_r.rvalid;
    assign rdata = st_r.rdata;
    assign rresp = st_r.rresp;

    // Operating style of each rail
    always_comb
    begin
        status_word = 32'h0;
        for (int i = 0; i < NRAIL; i++)
        begin
            status_word[2 * i +: 2] = rail[i].op;
        end
    end

    always_comb
    begin
        st_nxt = st_r;
        wr_hit = 1'b0;
        rd_hit = 1'b0;
        rd_data = 32'h0;

        // Responses retire
        if (st_r.bvalid && bready)
            st_nxt.bvalid = 1'b0;
        if (st_r.rvalid && rready)
            st_nxt.rvalid = 1'b0;

        // Address and data taken in either order
        if (awvalid && !st_r.aw_have)
        begin
            st_nxt.aw_have = 1'b1;
            st_nxt.aw_addr = awaddr;
        end
        if (wvalid && !st_r.w_have)
        begin
            st_nxt.w_have = 1'b1;
            st_nxt.wdata = wdata;
            st_nxt.wstrb = wstrb;
        end

        // Write once both halves held
        if (st_r.aw_have && st_r.w_have && !st_r.bvalid)
        begin
            for (int i = 0; i < NRAIL; i++)
            begin
                if (st_r.aw_addr == volt_addr(VOLT_IDX[i]))
                begin
                    wr_hit = 1'b1;
                    if (st_r.wstrb[0])
                        st_nxt.volt[i] = st_r.wdata[7:0];
                end
            end
            if (st_r.aw_addr == ADDR_MODE)
            begin
                wr_hit = 1'b1;
                if (st_r.wstrb[0])
                    st_nxt.mode[7:0] = st_r.wdata[7:0];
                if (st_r.wstrb[1])
                    st_nxt.mode[9:8] = st_r.wdata[9:8];
                if (st_r.wstrb[2])
                    st_nxt.a_sel = st_r.wdata[`BVS_MODE_SEL_BIT];
            end
            if (st_r.aw_addr == ADDR_STATUS)
                wr_hit = 1'b1;
            st_nxt.aw_have = 1'b0;
            st_nxt.w_have = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = wr_hit ? `BVS_RESP_OKAY : `BVS_RESP_SLVERR;
        end

        // Read answered one cycle after the address
        if (arvalid && !st_r.rvalid)
        begin
            for (int i = 0; i < NRAIL; i++)
            begin
                if (araddr == volt_addr(VOLT_IDX[i]))
                begin
                    rd_hit = 1'b1;
                    rd_data = {24'h0, st_r.volt[i]};
                end
            end
            if (araddr == ADDR_MODE)
            begin
                rd_hit = 1'b1;
                rd_data[9:0] = st_r.mode;
                rd_data[`BVS_MODE_SEL_BIT] = st_r.a_sel;
            end
            if (araddr == ADDR_STATUS)
            begin
                rd_hit = 1'b1;
                rd_data = status_word;
            end
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = rd_data;
            st_nxt.rresp = rd_hit ? `BVS_RESP_OKAY : `BVS_RESP_SLVERR;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            st_r <= '0;
            st_r.volt <= {NRAIL{`BVS_RST_VOLT}};
            st_r.mode <= `BVS_RST_MODE;
            st_r.a_sel <= `BVS_RST_ASEL;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // One regulator control per rail
    for (genvar g = 0; g < NRAIL; g++)
    begin : g_rail
        bvs_rail #(
            .BASE_MV(BASE_MV[g]),
            .STEP_MV(STEP_MV[g])
        ) u_rail (
            .mclk(mclk),
            .rst(rst),
            .setting(st_r.volt[g]),
            .mode(st_r.mode[2 * g +: 2]),
            .a_sel(st_r.a_sel),
            .rail(rail[g])
        );
    end

    default clocking cb @(posedge mclk);
    endclocking

    default disable iff (rst);

    core1_scale_a: assert property (
        1'b1 |=> (rail[0].mv ==
            12'h12c + 12'h00a * {5'h00, $past(st_r.volt[0][6:0])}))
        else $error("Core-1 voltage scale wrong");

    proc_scale_a: assert property (
        1'b1 |=> (rail[1].mv ==
            12'h212 + 12'h00a * {5'h00, $past(st_r.volt[1][6:0])}))
        else $error("Processor voltage scale wrong");

    wide_scale_a: assert property (
        1'b1 |=> (rail[2].mv ==
            12'h320 + 12'h014 * {5'h00, $past(st_r.volt[2][6:0])}) &&
            (rail[3].mv == 12'h320 + 12'h014 * {5'h00, $past(st_r.volt[3][6:0])}) &&
            (rail[4].mv == 12'h320 + 12'h014 * {5'h00, $past(st_r.volt[4][6:0])}))
        else $error("Wide rail voltage scale wrong");

    top_code_a: assert property (
        (st_r.volt[4][6:0] == 7'h7f) |=> (rail[4].mv == 12'hd0c))
        else $error("Peripheral top code not 3.34 V");

    write_lands_a: assert property (
        (st_r.aw_have && st_r.w_have && !st_r.bvalid &&
            st_r.aw_addr == ADDR_CORE1 && st_r.wstrb[0])
        |=> (st_r.volt[0] == $past(st_r.wdata[7:0])) && bvalid &&
            (bresp == `BVS_RESP_OKAY))
        else $error("Core-1 write not stored");

    read_back_a: assert property (
        (arvalid && arready && araddr == ADDR_PERI)
        |=> rvalid && (rdata == {24'h0, $past(st_r.volt[4])}) &&
            (rresp == `BVS_RESP_OKAY))
        else $error("Peripheral read back wrong");

    write_resp_a: assert property (
        (st_r.aw_have && st_r.w_have && !st_r.bvalid) |=> bvalid && awready && wready)
        else $error("Write response missing");

    read_hold_a: assert property (
        (rvalid && !rready) |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("Read data not held");

    unmapped_read_a: assert property (
        (arvalid && arready && araddr[1:0] != 2'h0)
        |=> rvalid && (rresp == `BVS_RESP_SLVERR) && (rdata == 32'h0))
        else $error("Unmapped read not refused");

    read_quiet_a: assert property (
        (arvalid && arready) |=> $stable(st_r.volt) || $past(st_r.bvalid) ||
            $past(st_r.aw_have && st_r.w_have))
        else $error("Read disturbed a register");

    // Register map checks
    status_read_a: assert property (
        (arvalid && arready && araddr == ADDR_STATUS)
        |=> rvalid && (rresp == `BVS_RESP_OKAY) &&
            (rdata == {22'h0, $past(rail[4].op), $past(rail[3].op), $past(rail[2].op),
                $past(rail[1].op), $past(rail[0].op)}))
        else $error("Status read wrong");

    mode_read_a: assert property (
        (arvalid && arready && araddr == ADDR_MODE)
        |=> rvalid && (rresp == `BVS_RESP_OKAY) &&
            (rdata == {15'h0, $past(st_r.a_sel), 6'h0, $past(st_r.mode)}))
        else $error("Mode read wrong");

    strobe_mask_a: assert property (
        (st_r.aw_have && st_r.w_have && !st_r.bvalid &&
            st_r.aw_addr == ADDR_CORE1 && !st_r.wstrb[0])
        |=> $stable(st_r.volt[0]) && bvalid && (bresp == `BVS_RESP_OKAY))
        else $error("Masked write changed core-1");

    unmapped_write_a: assert property (
        (st_r.aw_have && st_r.w_have && !st_r.bvalid && st_r.aw_addr[11:9] == 3'h0)
        |=> $stable(st_r.volt) && $stable(st_r.mode) && bvalid &&
            (bresp == `BVS_RESP_SLVERR))
        else $error("Unmapped write not refused");

    // Handshake checks
    aw_take_a: assert property (
        (awvalid && awready) |=> !awready)
        else $error("Address not held after take");

    w_take_a: assert property (
        (wvalid && wready) |=> !wready)
        else $error("Data not held after take");

    ar_take_a: assert property (
        (arvalid && arready) |=> rvalid && !arready)
        else $error("Read not answered next cycle");

    b_retire_a: assert property (
        (bvalid && bready) |=> !bvalid)
        else $error("Write response not retired");

    r_retire_a: assert property (
        (rvalid && rready) |=> !rvalid && arready)
        else $error("Read data not retired");

endmodule : bvs_top
`default_nettype wire

// ==== bvs_top_tb.sv ====
`default_nettype none
module bvs_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
$display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
    logic mclk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [11:0] awaddr, araddr, emv;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r, eop;
    bvs_pkg::bvs_rail_t [4:0] rail;
    int bad_count, checked, mreg, est;
    int vreg[5];
    int base[5] = '{300, 530, 800, 800, 800};
    int step[5] = '{10, 10, 20, 20, 20};

    bvs_top u_bvs_top (.mclk, .rst, .awvalid, .awready, .awaddr, .wvalid, .wready,
        .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
        .rvalid, .rready, .rdata, .rresp, .rail);

    initial
    begin
        mclk = 0;
        forever #20 mclk = ~mclk;
    end

    task automatic wr(input logic [11:0] a, input logic [31:0] dv, output logic [1:0] rs);
        bit aw, w;
        aw = 0;
        w = 0;
        awaddr <= a;
        wdata <= dv;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!(aw && w))
        begin
            @(posedge mclk);
            if (!aw && awready)
            begin
                aw = 1;
                awvalid <= 0;
            end
            if (!w && wready)
            begin
                w = 1;
                wvalid <= 0;
            end
        end
        do @(posedge mclk); while (!bvalid);
        rs = bresp;
        bready <= 0;
        @(posedge mclk);
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] dv, output logic [1:0] rs);
        araddr <= a;
        arvalid <= 1;
        do @(posedge mclk); while (!arready);
        arvalid <= 0;
        @(posedge mclk);
        rready <= 1;
        do @(posedge mclk); while (!rvalid);
        dv = rdata;
        rs = rresp;
        rready <= 0;
        @(posedge mclk);
    endtask : rd

    // Model of each rail output
    task automatic chk_rails;
        est = 0;
        for (int i = 0; i < 5; i++)
        begin
            int m;
            m = (mreg >> (2 * i)) & 3;
            eop = m == 1 ? 2'h1 : m == 2 ? 2'h0 : m == 3 ? 2'h2 :
                mreg[16] ? {1'b0, vreg[i][7]} : 2'h3;
            est = est | (int'(eop) << (2 * i));
            emv = 12'(base[i] + (vreg[i] & 127) * step[i]);
            `CHK(rail[i].op, eop)
            `CHK(rail[i].mv, emv)
        end
    endtask : chk_rails

    task automatic finish_test;
        $display("TB: checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test

    initial
    begin
        #(20000 * 40);
        bad_count++;
        finish_test;
    end

    initial
    begin
        rst = 1;
        awvalid = 0;
        wvalid = 0;
        arvalid = 0;
        bready = 0;
        rready = 0;
        awaddr = 12'h000;
        araddr = 12'h000;
        wdata = 32'h0;
        wstrb = 4'hf;
        mreg = 32'h10000;
        vreg = '{default: 0};
        void'($urandom(32'hdef4));
        repeat (16) @(posedge mclk);
        rst <= 0;
        @(posedge mclk);
        chk_rails;
        for (int i = 0; i < 5; i++)
        begin
            rd(12'h290 + 12'(4 * i), d, r);
            `CHK(d, 32'h0)
            `CHK(r, 2'h0)
        end
        $display("TB: reset test done");
        // Boundary codes, every mode, then random traffic
        for (int n = 0; n < 40; n++)
        begin
            int i;
            logic [7:0] v;
            logic [31:0] md;
            i = $urandom_range(4);
            v = n == 0 ? 8'h7f : n == 1 ? 8'h80 : n == 2 ? 8'hff : 8'($urandom);
            md = n < 5 ? {15'h0, 1'(n < 4), 6'h0, {5{2'(n)}}} : $urandom & 32'h103ff;
            wr(12'h290 + 12'(4 * i), {24'h0, v}, r);
            `CHK(r, 2'h0)
            vreg[i] = v;
            wr(12'h2c0, md, r);
            `CHK(r, 2'h0)
            mreg = md;
            repeat (2) @(posedge mclk);
            chk_rails;
            rd(12'h290 + 12'(4 * i), d, r);
            `CHK(d, {24'h0, v})
        end
        $display("TB: write test done");
        wr(12'h004, 32'hff, r);
        `CHK(r, 2'h2)
        rd(12'h291, d, r);
        `CHK(r, 2'h2)
        `CHK(d, 32'h0)
        repeat (2) @(posedge mclk);
        chk_rails;
        wstrb <= 4'he;
        wr(12'h290, 32'h55, r);
        `CHK(r, 2'h0)
        wstrb <= 4'hf;
        rd(12'h290, d, r);
        `CHK(d, vreg[0])
        wr(12'h2c4, 32'hffffffff, r);
        `CHK(r, 2'h0)
        chk_rails;
        rd(12'h2c4, d, r);
        `CHK(d, est)
        rd(12'h2c0, d, r);
        `CHK(d, mreg & 32'h103ff)
        $display("TB: error test done");
        finish_test;
    end
endmodule : bvs_top_tb
`default_nettype wire
